//--- inc/tmr_evgen_pkg.sv
// Constants and carrier types for the timer event generator and channel 1 mode block.
// Assumes a single 10 MHz clock domain and a plain strobe register port.
// Behaviour
// - Update-generate bit restarts counter, raises update
// - Output channel event sets flag, interrupts
// - Input channel event captures counter, sets flag
// - Capture with flag set marks repeat
// - Channels 2 and 3 event bits alike
// - Trigger bit makes trigger; zero writes ignored
// - Direction field: output, input one/two/trigger
// - Direction writable only while channel disabled
// - Preload defers compare writes to update
// - Lock level 3 output freezes preload bit
// - Compare mode 000 freezes reference output
// - Compare mode 001 sets high on match
// - Other modes: low, toggle, force, PWM
// - Capture flag cleared by write or read
package tmr_evgen_pkg;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_REPEAT = 8'h14;
  localparam logic [7:0] OFS_EVGEN = 8'h18;
  localparam logic [7:0] OFS_MODE = 8'h1C;
  localparam logic [7:0] OFS_COMPARE1 = 8'h34;
  localparam logic [7:0] OFS_COUNTER = 8'h24;
  localparam logic [7:0] OFS_CONTROL = 8'h20;
  localparam logic [7:0] OFS_INTEN = 8'h0C;
  localparam logic [7:0] OFS_INTCLR = 8'h28;
  localparam int BIT_UPD = 0;
  localparam int BIT_CH1 = 1;
  localparam int BIT_TRG = 6;
  localparam int BIT_PRELOAD = 3;
  localparam int MODE_LSB = 4;
  localparam logic [1:0] LOCK_FULL = 2'h3;
  localparam logic [31:0] MODE_RESET = 32'h00000000;

  typedef enum logic [1:0] {DIR_OUT, DIR_TI1, DIR_TI2, DIR_TRC} dir_t;
  typedef enum logic [2:0] {
    OCM_FROZEN, OCM_MATCH_HIGH, OCM_MATCH_LOW, OCM_TOGGLE,
    OCM_FORCE_LOW, OCM_FORCE_HIGH, OCM_PWM1, OCM_PWM2
  } ocm_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  typedef struct packed {
    dir_t dir;
    logic preload;
    ocm_t ocm;
  } mode_t;
endpackage

//--- core/timer_event_gen_channel_mode.sv
// Timer event generator and channel 1 mode logic with a small counter and 3 channels.
// Assumes a synchronous register master that never waits and one clock.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
module timer_event_gen_channel_mode #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Register port
  input wire tmr_evgen_pkg::bus_req_t busReq,
  output logic [31:0] rdata,
  // Channel 1 output and system events
  output logic ch1RefOut,
  output logic updateEvent,
  output logic triggerEvent,
  output logic irq
);
  // Refuse counter widths that the 32-bit register port cannot carry
  generate
    if (CNT_W < 2 || CNT_W > 32) begin : g_bad_width
      $error("CNT_W out of range");
    end
  endgenerate

  typedef struct packed {
    // Registered read data, zero outside the answer cycle
    logic [31:0] rdata;
    // Counter and its auto-reload limit
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] arr;
    // Capture/compare values per channel and the channel 1 shadow
    logic [2:0][CNT_W-1:0] cc;
    logic [CNT_W-1:0] ccShadow;
    // Channel 1 mode fields
    tmr_evgen_pkg::mode_t mode;
    // Sticky flags and their enables; bits 5:4 stay zero
    logic [6:0] status;
    logic [3:1] repeatFlag;
    logic [6:0] intEn;
    // Control: run, channel 1 enable, lock level
    logic [3:0] ctrl;
    // Registered outputs
    logic ref1;
    logic upd;
    logic trg;
    logic irq;
  } state_t;

  state_t cur_ff;
  state_t nxt_cur;
  logic [2:0] chIsOut;

  // Channels 2 and 3 have no mode register here; they are fixed as inputs
  assign chIsOut = {1'b0, 1'b0, cur_ff.mode.dir == tmr_evgen_pkg::DIR_OUT};

  // Write strobes and the compare read strobe decoded once; the read mux below decodes the address itself
  logic wrEvgen;
  logic wrStatus;
  logic wrIntClr;
  logic wrRepeat;
  logic wrMode;
  logic wrCompare;
  logic wrReload;
  logic wrControl;
  logic wrIntEn;
  logic rdCompare;
  assign wrEvgen = busReq.wr && busReq.addr == tmr_evgen_pkg::OFS_EVGEN;
  assign wrStatus = busReq.wr && busReq.addr == tmr_evgen_pkg::OFS_STATUS;
  assign wrIntClr = busReq.wr && busReq.addr == tmr_evgen_pkg::OFS_INTCLR;
  assign wrRepeat = busReq.wr && busReq.addr == tmr_evgen_pkg::OFS_REPEAT;
  assign wrMode = busReq.wr && busReq.addr == tmr_evgen_pkg::OFS_MODE;
  assign wrCompare = busReq.wr && busReq.addr == tmr_evgen_pkg::OFS_COMPARE1;
  assign wrReload = busReq.wr && busReq.addr == tmr_evgen_pkg::OFS_COUNTER;
  assign wrControl = busReq.wr && busReq.addr == tmr_evgen_pkg::OFS_CONTROL;
  assign wrIntEn = busReq.wr && busReq.addr == tmr_evgen_pkg::OFS_INTEN;
  assign rdCompare = busReq.rd && busReq.addr == tmr_evgen_pkg::OFS_COMPARE1;

  // Software update request; it also restarts the counter
  logic updReq;
  assign updReq = wrEvgen && busReq.wdata[tmr_evgen_pkg::BIT_UPD];

  // Counter wrap at the auto-reload value, only while the counter runs
  logic wrapNow;
  assign wrapNow = cur_ff.ctrl[0] && cur_ff.cnt == cur_ff.arr;

  // Trigger request; a zero bit in the word does nothing
  logic trgReq;
  assign trgReq = wrEvgen && busReq.wdata[tmr_evgen_pkg::BIT_TRG];

  // Per-channel event decode, one slice per channel
  logic [2:0] chEvent;
  logic [2:0] chCapture;
  logic [2:0] chRepeat;
  generate
    for (genvar g = 0; g < 3; g++) begin : g_chan
      // Any channel event raises its flag, output or input alike
      assign chEvent[g] = wrEvgen && busReq.wdata[tmr_evgen_pkg::BIT_CH1 + g];
      // Input channels also latch the counter value
      assign chCapture[g] = chEvent[g] && !chIsOut[g];
      // A capture over an unread flag is an overrun worth reporting
      assign chRepeat[g] = chCapture[g] && cur_ff.status[1 + g];
    end
  endgenerate

  always_comb begin
    logic rd;
    logic [7:0] a;
    logic [31:0] d;
    logic match;
    logic lockOut;
    rd = busReq.rd;
    a = busReq.addr;
    d = busReq.wdata;
    match = 1'b0;
    // Preload bit is frozen at the top lock level while the channel drives
    lockOut = cur_ff.ctrl[3:2] == tmr_evgen_pkg::LOCK_FULL
              && cur_ff.mode.dir == tmr_evgen_pkg::DIR_OUT;
    nxt_cur = cur_ff;
    // Event outputs are one-cycle pulses unless raised again below
    nxt_cur.upd = 1'b0;
    nxt_cur.trg = 1'b0;
    // Read data stands only in the cycle after a read strobe
    nxt_cur.rdata = 32'h00000000;
    // Free-running up counter; wrap or software update restarts it
    if (updReq) begin
      nxt_cur.cnt = '0;
    end else if (cur_ff.ctrl[0]) begin
      nxt_cur.cnt = wrapNow ? '0 : cur_ff.cnt + 1'b1;
    end
    // Clears go first, so a hardware set in the same cycle wins
    if (rdCompare) begin
      nxt_cur.status[1] = 1'b0;
    end
    // Status write: a zero clears, a one keeps what is there
    if (wrStatus) begin
      nxt_cur.status = nxt_cur.status & {d[6], 2'b11, d[3:0]};
    end
    // Clear register: a one clears, a zero keeps
    if (wrIntClr) begin
      nxt_cur.status = nxt_cur.status & ~{d[6], 2'b00, d[3:0]};
    end
    // Repeat flags clear like the status register
    if (wrRepeat) begin
      nxt_cur.repeatFlag = nxt_cur.repeatFlag & d[3:1];
    end
    // Update event from software or from a counter wrap
    if (updReq || wrapNow) begin
      nxt_cur.upd = 1'b1;
      nxt_cur.status[0] = 1'b1;
      // Shadowed compare value moves in only here when preloading
      if (cur_ff.mode.preload) begin
        nxt_cur.cc[0] = cur_ff.ccShadow;
      end
    end
    // Per-channel software events; a zero bit does nothing
    for (int i = 0; i < 3; i++) begin
      if (chEvent[i]) begin
        nxt_cur.status[1 + i] = 1'b1;
      end
      if (chCapture[i]) begin
        nxt_cur.cc[i] = cur_ff.cnt;
      end
      if (chRepeat[i]) begin
        nxt_cur.repeatFlag[1 + i] = 1'b1;
      end
    end
    // Trigger event pulse and its sticky flag
    if (trgReq) begin
      nxt_cur.trg = 1'b1;
      nxt_cur.status[6] = 1'b1;
    end
    // Keep reserved status bits at zero
    nxt_cur.status[5:4] = 2'b00;
    // Mode register write with direction and preload protections
    if (wrMode) begin
      if (!cur_ff.ctrl[1]) begin
        nxt_cur.mode.dir = tmr_evgen_pkg::dir_t'(d[1:0]);
      end
      if (!lockOut) begin
        nxt_cur.mode.preload = d[tmr_evgen_pkg::BIT_PRELOAD];
      end
      nxt_cur.mode.ocm = tmr_evgen_pkg::ocm_t'(d[tmr_evgen_pkg::MODE_LSB +: 3]);
    end
    // Compare value goes straight in or waits in the shadow
    if (wrCompare) begin
      nxt_cur.ccShadow = d[CNT_W-1:0];
      if (!cur_ff.mode.preload) begin
        nxt_cur.cc[0] = d[CNT_W-1:0];
      end
    end
    // Auto-reload limit; the counter wraps after reaching it
    if (wrReload) begin
      nxt_cur.arr = d[CNT_W-1:0];
    end
    // Control word; a new lock level applies from the next write on
    if (wrControl) begin
      nxt_cur.ctrl = d[3:0];
    end
    // Interrupt enables share the status layout
    if (wrIntEn) begin
      nxt_cur.intEn = {d[6], 2'b00, d[3:0]};
    end
    // Reference output per compare mode; PWM without preload is the user's risk
    match = cur_ff.cnt == cur_ff.cc[0];
    case (cur_ff.mode.ocm)
      // Frozen: compare matches leave the output alone
      tmr_evgen_pkg::OCM_FROZEN: begin
        nxt_cur.ref1 = cur_ff.ref1;
      end
      // Match high: set on equality, hold otherwise
      tmr_evgen_pkg::OCM_MATCH_HIGH: begin
        if (match) begin
          nxt_cur.ref1 = 1'b1;
        end
      end
      // Match low: clear on equality, hold otherwise
      tmr_evgen_pkg::OCM_MATCH_LOW: begin
        if (match) begin
          nxt_cur.ref1 = 1'b0;
        end
      end
      // Toggle: a counter parked on the compare value toggles every cycle
      tmr_evgen_pkg::OCM_TOGGLE: begin
        if (match) begin
          nxt_cur.ref1 = ~cur_ff.ref1;
        end
      end
      // Forced levels ignore the counter
      tmr_evgen_pkg::OCM_FORCE_LOW: begin
        nxt_cur.ref1 = 1'b0;
      end
      tmr_evgen_pkg::OCM_FORCE_HIGH: begin
        nxt_cur.ref1 = 1'b1;
      end
      // PWM: the level follows the comparison result every cycle
      tmr_evgen_pkg::OCM_PWM1: begin
        nxt_cur.ref1 = cur_ff.cnt < cur_ff.cc[0];
      end
      tmr_evgen_pkg::OCM_PWM2: begin
        nxt_cur.ref1 = cur_ff.cnt > cur_ff.cc[0];
      end
      default: begin
        nxt_cur.ref1 = cur_ff.ref1;
      end
    endcase
    // Read mux; event register is write only and reads zero
    if (rd) begin
      case (a)
        // Mode fields packed back into place; reserved bits read zero
        tmr_evgen_pkg::OFS_MODE: begin
          nxt_cur.rdata = {25'h0, cur_ff.mode.ocm, cur_ff.mode.preload, 1'b0,
                           cur_ff.mode.dir};
        end
        // Flags and enables
        tmr_evgen_pkg::OFS_STATUS: begin
          nxt_cur.rdata = {25'h0, cur_ff.status};
        end
        tmr_evgen_pkg::OFS_REPEAT: begin
          nxt_cur.rdata = {28'h0, cur_ff.repeatFlag, 1'b0};
        end
        tmr_evgen_pkg::OFS_INTEN: begin
          nxt_cur.rdata = {25'h0, cur_ff.intEn};
        end
        // Control bits
        tmr_evgen_pkg::OFS_CONTROL: begin
          nxt_cur.rdata = {28'h0, cur_ff.ctrl};
        end
        // Channel 1 capture value; this read also clears the channel 1 flag
        tmr_evgen_pkg::OFS_COMPARE1: begin
          nxt_cur.rdata = 32'(cur_ff.cc[0]);
        end
        // Auto-reload limit
        tmr_evgen_pkg::OFS_COUNTER: begin
          nxt_cur.rdata = 32'(cur_ff.arr);
        end
        // Event register and unmapped offsets read zero
        default: begin
          nxt_cur.rdata = 32'h00000000;
        end
      endcase
    end
    nxt_cur.irq = |(nxt_cur.status & nxt_cur.intEn);
  end

  // All state in one register
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cur_ff <= '0;
      cur_ff.arr <= '1;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // Every output is a plain copy of a state flip-flop
  assign rdata = cur_ff.rdata;
  // Reference level for the output stage
  assign ch1RefOut = cur_ff.ref1;
  // One-cycle event pulses for the rest of the timer
  assign updateEvent = cur_ff.upd;
  assign triggerEvent = cur_ff.trg;
  // Level interrupt, high while an enabled flag is up
  assign irq = cur_ff.irq;
endmodule

//--- dv/timer_event_gen_channel_mode_assertions.sv
// Port checker for the timer event generator and channel 1 mode block.
// Assumes the package register map and a bench that keeps the counter stopped.
`timescale 1ns/1ps
module timer_event_gen_channel_mode_assertions #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Watched ports
  input wire tmr_evgen_pkg::bus_req_t busReq,
  input wire logic [31:0] rdata,
  input wire logic ch1RefOut,
  input wire logic updateEvent,
  input wire logic triggerEvent,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Event register write with one bit set
  sequence s_ev(int b);
    busReq.wr && busReq.addr == 8'h18 && busReq.wdata[b];
  endsequence
  // Mode write choosing an output channel with a given compare mode
  sequence s_mode(logic [2:0] m);
    busReq.wr && busReq.addr == 8'h1C && busReq.wdata[6:4] == m && busReq.wdata[1:0] == 2'h0;
  endsequence
  a_upd_pulse: assert property (s_ev(0) |=> updateEvent)
    else $error("update pulse missing");
  a_evgen_reads_zero: assert property (busReq.rd && busReq.addr == 8'h18 |=> rdata == 32'h0)
    else $error("event register not zero");
  a_trg_pulse: assert property (s_ev(6) |=> triggerEvent)
    else $error("trigger pulse missing");
  a_trg_cause: assert property (triggerEvent |-> $past(busReq.wr && busReq.addr == 8'h18
    && busReq.wdata[6]))
    else $error("trigger without request");
  a_ch1_flag_set: assert property (s_ev(1) ##1 !(busReq.wr || busReq.rd)
    ##1 (busReq.rd && busReq.addr == 8'h10) |=> rdata[1])
    else $error("channel 1 flag not set");
  a_mode_rsvd_zero: assert property (busReq.rd && busReq.addr == 8'h1C
    |=> rdata[31:7] == 25'h0 && !rdata[2])
    else $error("reserved mode bits set");
  a_force_high: assert property (s_mode(3'h5) ##1 !busReq.wr |-> ##1 ch1RefOut)
    else $error("forced high missing");
  a_force_low: assert property (s_mode(3'h4) ##1 !busReq.wr |-> ##1 !ch1RefOut)
    else $error("forced low missing");
endmodule
bind timer_event_gen_channel_mode timer_event_gen_channel_mode_assertions #(.CNT_W(CNT_W)) u_chk (
  .clk(clk), .nrst(nrst), .busReq(busReq), .rdata(rdata), .ch1RefOut(ch1RefOut),
  .updateEvent(updateEvent), .triggerEvent(triggerEvent), .irq(irq));

//--- dv/tb_timer_event_gen_channel_mode.sv
// Self-checking bench for the timer event generator and channel 1 mode block.
// Assumes the checker is bound; the bench is the only register master.
`timescale 1ns/1ps
module tb_timer_event_gen_channel_mode;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  tmr_evgen_pkg::bus_req_t busReq = '0;
  logic [31:0] rdata;
  logic ch1RefOut, updateEvent, triggerEvent, irq;
  int error_cnt = 0;
  int checks = 0;
  logic [2:0] ocmTab [5] = '{3'h4, 3'h0, 3'h1, 3'h2, 3'h5};
  logic expTab [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
  // 10 MHz clock
  always #50 clk = ~clk;
  timer_event_gen_channel_mode u_timer_event_gen_channel_mode (.clk(clk), .nrst(nrst),
    .busReq(busReq), .rdata(rdata), .ch1RefOut(ch1RefOut), .updateEvent(updateEvent),
    .triggerEvent(triggerEvent), .irq(irq));
  // Comparisons, counted
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic cmpb(input string n, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %b got %b", n, e, g);
    end
  endtask
  // One-cycle strobes; returns just after the taking edge so pulses can be seen
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    busReq.wr <= 1'b0;
    #1;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string n);
    @(posedge clk);
    busReq <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    busReq.rd <= 1'b0;
    #1;
    cmp(n, e, rdata);
  endtask
  task automatic test_done;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Watchdog, far beyond the hundred or so cycles the tests need
  initial begin
    #1000000;
    error_cnt++;
    test_done();
  end
  // Main sequence; counter stays stopped so it rests at zero
  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    rdc(8'h1C, 32'h0, "mode reset");
    wr(8'h0C, 32'h4F);
    wr(8'h18, 32'h1);
    cmpb("update", 1'b1, updateEvent);
    rdc(8'h18, 32'h0, "evgen read");
    wr(8'h18, 32'h40);
    cmpb("trigger", 1'b1, triggerEvent);
    wr(8'h18, 32'h0);
    cmpb("zero write", 1'b0, triggerEvent | updateEvent);
    wr(8'h28, 32'h4F);
    wr(8'h18, 32'h2);
    cmpb("ch1 irq", 1'b1, irq);
    rdc(8'h10, 32'h2, "ch1 flag");
    wr(8'h28, 32'h4F);
    wr(8'h0C, 32'h0);
    wr(8'h18, 32'h2);
    cmpb("masked irq", 1'b0, irq);
    wr(8'h28, 32'h4F);
    wr(8'h1C, 32'h1);
    wr(8'h18, 32'hE);
    rdc(8'h10, 32'hE, "flags");
    rdc(8'h14, 32'h0, "no repeat");
    wr(8'h18, 32'hE);
    rdc(8'h14, 32'hE, "repeat");
    rdc(8'h34, 32'h0, "capture");
    rdc(8'h10, 32'hC, "read clears");
    // Direction field is frozen while the channel is on
    wr(8'h20, 32'h2);
    wr(8'h1C, 32'h2);
    rdc(8'h1C, 32'h1, "dir locked");
    wr(8'h20, 32'h0);
    for (int i = 3; i >= 0; i--) begin
      wr(8'h1C, 32'(i));
      rdc(8'h1C, 32'(i), "dir");
    end
    wr(8'h20, 32'hC);
    wr(8'h1C, 32'h8);
    rdc(8'h1C, 32'h0, "preload locked");
    wr(8'h20, 32'h0);
    wr(8'h1C, 32'hFFFFFF7C);
    rdc(8'h1C, 32'h78, "reserved");
    // Compare modes with counter and compare both at zero, so every cycle matches
    wr(8'h1C, 32'h0);
    wr(8'h34, 32'h0);
    for (int i = 0; i < 5; i++) begin
      wr(8'h1C, {25'h0, ocmTab[i], 4'h0});
      repeat (2) @(posedge clk);
      cmpb("ref out", expTab[i], ch1RefOut);
    end
    // Preloaded compare waits for the update event
    wr(8'h1C, 32'h40);
    wr(8'h34, 32'h5);
    wr(8'h1C, 32'h48);
    wr(8'h34, 32'h0);
    wr(8'h1C, 32'h18);
    repeat (2) @(posedge clk);
    cmpb("preloaded", 1'b0, ch1RefOut);
    wr(8'h18, 32'h1);
    repeat (2) @(posedge clk);
    cmpb("after update", 1'b1, ch1RefOut);
    test_done();
  end
endmodule
